// [inc/mmcm_map.svh]
// register offsets, field positions, reset values and counts of the coil map
// assumes holding registers are addressed by their 16-bit offset
`ifndef MMCM_MAP_SVH
`define MMCM_MAP_SVH
// basic meter holding registers
`define MMCM_POLL_BASIC 16'h9c51
`define MMCM_RESET_BASIC 16'h9c52
`define MMCM_OUT_BASIC 16'h9c55
`define MMCM_STORE_BASIC 16'h9c56
// other meter types
`define MMCM_POLL_LOW 16'h9c61
`define MMCM_POLL_HIGH 16'h9c62
`define MMCM_OUT_STATE 16'h9c66
`define MMCM_RESET_CMD 16'h9c67
`define MMCM_STORE_LOW 16'h9c69
`define MMCM_STORE_HIGH 16'h9c6a
// response delay bit positions
`define MMCM_DELAY_BIT_BASIC 4'ha
`define MMCM_DELAY_BIT_HIGH 4'h3
// reset values and answers
`define MMCM_POLL_FACTORY 16'hffff
`define MMCM_STORE_FACTORY 16'h0000
`define MMCM_UNUSED_READ 16'h8000
// terminators
`define MMCM_TERM_SKIP 8'h24
`define MMCM_TERM_STORE 8'h2a
// values walked by the background loop
`define MMCM_VALUES_BASIC 10
`define MMCM_VALUES_FULL 19
`endif

// [inc/mmcm_pkg.sv]
// types shared by the coil map: requests, meter commands, coil decode, states
// assumes nothing beyond a SystemVerilog compiler
package mmcm_pkg;
	typedef enum logic [2:0] {MMCM_COIL_RD, MMCM_COIL_WR, MMCM_REG_RD, MMCM_REG_WR,
		MMCM_VAL_RD, MMCM_VAL_WR} mmcm_kind_t;
	typedef struct packed {
		mmcm_kind_t kind;
		logic [15:0] addr;
		logic [15:0] data;
	} mmcm_req_t;
	typedef struct packed {
		logic write;
		logic [4:0] idx;
		logic [15:0] wdata;
		logic [7:0] term;
	} mmcm_meter_cmd_t;
	typedef enum logic [2:0] {MMCM_SEL_NONE, MMCM_SEL_OUT, MMCM_SEL_RST, MMCM_SEL_PLO,
		MMCM_SEL_PHI, MMCM_SEL_SLO, MMCM_SEL_SHI} mmcm_sel_t;
	typedef struct packed {
		mmcm_sel_t sel;
		logic [3:0] bitn;
	} mmcm_coil_t;
	typedef enum logic [2:0] {MMCM_ST_IDLE, MMCM_ST_BG, MMCM_ST_MRD, MMCM_ST_MWR,
		MMCM_ST_MRB} mmcm_state_t;
endpackage

// [verilog/mmcm_coil_map.sv]
// coil and holding-register map of the serial option card, with background poll loop
// assumes a master front end that delivers decoded requests and a meter link port
`timescale 1ns/1ps
`include "mmcm_map.svh"

module mmcm_coil_map import mmcm_pkg::*; #(
	parameter int VALUES_BASIC = `MMCM_VALUES_BASIC,
	parameter int VALUES_FULL = `MMCM_VALUES_FULL
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic meter_is_basic,
	input wire logic req_valid,
	input wire mmcm_req_t req,
	output logic req_ready,
	output logic resp_valid,
	output logic [15:0] resp_data,
	input wire logic [3:0] setpoint_state,
	input wire logic [3:0] manual_mode,
	output logic out_force_valid,
	output logic [3:0] out_force_value,
	output logic reset_valid,
	output logic [15:0] reset_mask,
	output logic meter_cmd_valid,
	output mmcm_meter_cmd_t meter_cmd,
	input wire logic meter_done,
	input wire logic [15:0] meter_rdata,
	input wire logic nv_valid,
	input wire logic [15:0] nv_poll_low,
	input wire logic [15:0] nv_poll_high,
	output logic nv_save_valid,
	output logic [31:0] nv_save_data
);
	// coil number to storage word and bit, per meter variant
	function automatic mmcm_coil_t coil_map(input logic [15:0] n, input logic b);
		mmcm_coil_t m;
		logic [15:0] d;
		m.sel = MMCM_SEL_NONE;
		m.bitn = 4'h0;
		d = 16'h0000;
		if (n < 16'h0004) begin
			m.sel = MMCM_SEL_OUT;
			m.bitn = n[3:0];
		end else if (b) begin
			unique case (n) inside
				16'h0004: begin m.sel = MMCM_SEL_RST; m.bitn = 4'h2; end
				16'h0005: begin m.sel = MMCM_SEL_RST; m.bitn = 4'h3; end
				16'h0009: begin m.sel = MMCM_SEL_RST; m.bitn = 4'h4; end
				[16'h000a:16'h0013]: begin d = n - 16'h000a; m.sel = MMCM_SEL_PLO; end
				[16'h0014:16'h001c]: begin d = n - 16'h0014; m.sel = MMCM_SEL_SLO; end
				16'h001d: begin m.sel = MMCM_SEL_PLO; m.bitn = `MMCM_DELAY_BIT_BASIC; end
				default: m.sel = MMCM_SEL_NONE;
			endcase
			if (m.sel == MMCM_SEL_PLO && n != 16'h001d || m.sel == MMCM_SEL_SLO) begin
				m.bitn = d[3:0];
			end
		end else begin
			unique case (n) inside
				16'h0004: begin m.sel = MMCM_SEL_RST; m.bitn = 4'h2; end
				16'h0005: begin m.sel = MMCM_SEL_RST; m.bitn = 4'h3; end
				16'h0006: begin m.sel = MMCM_SEL_RST; m.bitn = 4'h7; end
				16'h0007: begin m.sel = MMCM_SEL_RST; m.bitn = 4'h6; end
				16'h0008: begin m.sel = MMCM_SEL_RST; m.bitn = 4'h5; end
				// poll bits, counter start poll lands on bit five
				[16'h000a:16'h0019]: begin d = n - 16'h000a; m.sel = MMCM_SEL_PLO; end
				[16'h001a:16'h001d]: begin d = n - 16'h001a; m.sel = MMCM_SEL_PHI; end
				[16'h001e:16'h002d]: begin d = n - 16'h001e; m.sel = MMCM_SEL_SLO; end
				[16'h002e:16'h0030]: begin d = n - 16'h002e; m.sel = MMCM_SEL_SHI; end
				default: m.sel = MMCM_SEL_NONE;
			endcase
			if (m.sel inside {MMCM_SEL_PLO, MMCM_SEL_PHI, MMCM_SEL_SLO, MMCM_SEL_SHI}) begin
				m.bitn = d[3:0];
			end
		end
		return m;
	endfunction

	mmcm_state_t state_ff, nxt_state; // sequencer state
	logic basic_ff, nxt_basic; // variant strap caught after reset
	logic caught_ff, nxt_caught; // strap taken
	logic boot_ff, nxt_boot; // power-up sweep in progress
	logic [15:0] poll_lo_ff, nxt_poll_lo; // poll select low word
	logic [15:0] poll_hi_ff, nxt_poll_hi; // poll select high word
	logic [15:0] store_lo_ff, nxt_store_lo; // store select low word
	logic [15:0] store_hi_ff, nxt_store_hi; // store select high word
	logic [4:0] idx_ff, nxt_idx; // background loop index
	logic resp_valid_ff, nxt_resp_valid;
	logic [15:0] resp_data_ff, nxt_resp_data;
	logic force_ff, nxt_force;
	logic [3:0] force_val_ff, nxt_force_val;
	logic rst_ff, nxt_rst;
	logic [15:0] rst_mask_ff, nxt_rst_mask;
	logic cmd_valid_ff, nxt_cmd_valid;
	mmcm_meter_cmd_t cmd_ff, nxt_cmd;
	logic save_ff, nxt_save;
	mmcm_coil_t cm; // decode of the requested coil
	logic take; // request accepted this cycle
	logic delay_on; // response delay coil
	logic [31:0] poll_all, store_all; // masks indexed by value
	logic [4:0] last_idx; // last value index of this variant
	logic [15:0] reg_rd; // holding register read word
	logic coil_rd; // coil read bit

	assign req_ready = (state_ff == MMCM_ST_IDLE);
	assign take = req_valid && req_ready;
	// frame carries zero-based number, which is the one-based address minus one
	assign cm = coil_map(req.addr, basic_ff);
	assign poll_all = {poll_hi_ff, poll_lo_ff};
	assign store_all = {store_hi_ff, store_lo_ff};
	assign delay_on = basic_ff ? poll_lo_ff[`MMCM_DELAY_BIT_BASIC]
		: poll_hi_ff[`MMCM_DELAY_BIT_HIGH];
	assign last_idx = basic_ff ? 5'(VALUES_BASIC - 1) : 5'(VALUES_FULL - 1);

	// read paths for coils and holding registers
	always_comb begin
		unique case (cm.sel)
			MMCM_SEL_OUT: coil_rd = setpoint_state[cm.bitn[1:0]];
			MMCM_SEL_PLO: coil_rd = poll_lo_ff[cm.bitn];
			MMCM_SEL_PHI: coil_rd = poll_hi_ff[cm.bitn];
			MMCM_SEL_SLO: coil_rd = store_lo_ff[cm.bitn];
			MMCM_SEL_SHI: coil_rd = store_hi_ff[cm.bitn];
			default: coil_rd = 1'b0; // reset coils read zero
		endcase
		reg_rd = `MMCM_UNUSED_READ;
		if (basic_ff) begin
			unique case (req.addr)
				`MMCM_POLL_BASIC: reg_rd = poll_lo_ff;
				`MMCM_RESET_BASIC: reg_rd = 16'h0000;
				`MMCM_OUT_BASIC: reg_rd = {12'h000, setpoint_state};
				`MMCM_STORE_BASIC: reg_rd = store_lo_ff;
				default: reg_rd = `MMCM_UNUSED_READ;
			endcase
		end else begin
			unique case (req.addr)
				`MMCM_POLL_LOW: reg_rd = poll_lo_ff;
				`MMCM_POLL_HIGH: reg_rd = poll_hi_ff;
				`MMCM_OUT_STATE: reg_rd = {12'h000, setpoint_state};
				`MMCM_RESET_CMD: reg_rd = 16'h0000;
				`MMCM_STORE_LOW: reg_rd = store_lo_ff;
				`MMCM_STORE_HIGH: reg_rd = store_hi_ff;
				default: reg_rd = `MMCM_UNUSED_READ;
			endcase
		end
	end

	// request handling, background loop and meter sequencing
	always_comb begin
		nxt_state = state_ff;
		nxt_basic = basic_ff;
		nxt_caught = 1'b1;
		nxt_boot = boot_ff;
		nxt_poll_lo = poll_lo_ff;
		nxt_poll_hi = poll_hi_ff;
		nxt_store_lo = store_lo_ff;
		nxt_store_hi = store_hi_ff;
		nxt_idx = idx_ff;
		nxt_resp_valid = 1'b0;
		nxt_resp_data = resp_data_ff;
		nxt_force = 1'b0;
		nxt_force_val = force_val_ff;
		nxt_rst = 1'b0;
		nxt_rst_mask = rst_mask_ff;
		nxt_cmd_valid = cmd_valid_ff;
		nxt_cmd = cmd_ff;
		nxt_save = 1'b0;
		if (!caught_ff) begin
			nxt_basic = meter_is_basic;
		end
		// stored poll settings replace factory ones
		if (nv_valid && state_ff == MMCM_ST_IDLE && !take) begin
			nxt_poll_lo = nv_poll_low;
			nxt_poll_hi = nv_poll_high;
		end
		unique case (state_ff)
			MMCM_ST_IDLE: begin
				if (take) begin
					nxt_resp_valid = 1'b1;
					unique case (req.kind)
						MMCM_COIL_RD: nxt_resp_data = {15'h0000, coil_rd};
						MMCM_REG_RD: nxt_resp_data = reg_rd;
						MMCM_COIL_WR: begin
							nxt_resp_data = req.data;
							unique case (cm.sel)
								MMCM_SEL_OUT: begin
									// forcing only takes effect in manual mode
									nxt_force = manual_mode[cm.bitn[1:0]];
									nxt_force_val = setpoint_state;
									nxt_force_val[cm.bitn[1:0]] = req.data[0];
								end
								MMCM_SEL_RST: begin
									nxt_rst = req.data[0];
									nxt_rst_mask = 16'h0001 << cm.bitn;
								end
								MMCM_SEL_PLO: begin
									nxt_poll_lo[cm.bitn] = req.data[0];
									nxt_save = 1'b1;
								end
								MMCM_SEL_PHI: begin
									nxt_poll_hi[cm.bitn] = req.data[0];
									nxt_save = 1'b1;
								end
								MMCM_SEL_SLO: nxt_store_lo[cm.bitn] = req.data[0];
								MMCM_SEL_SHI: nxt_store_hi[cm.bitn] = req.data[0];
								default: nxt_force = 1'b0;
							endcase
						end
						MMCM_REG_WR: begin
							nxt_resp_data = req.data;
							if (req.addr == (basic_ff ? `MMCM_OUT_BASIC : `MMCM_OUT_STATE)) begin
								// only manual outputs take the written state
								nxt_force = 1'b1;
								nxt_force_val = (req.data[3:0] & manual_mode)
									| (setpoint_state & ~manual_mode);
							end else if (req.addr == (basic_ff ? `MMCM_RESET_BASIC
								: `MMCM_RESET_CMD)) begin
								nxt_rst = |req.data;
								nxt_rst_mask = req.data;
							end else if (req.addr == (basic_ff ? `MMCM_POLL_BASIC
								: `MMCM_POLL_LOW)) begin
								nxt_poll_lo = req.data;
								nxt_save = 1'b1;
							end else if (!basic_ff && req.addr == `MMCM_POLL_HIGH) begin
								nxt_poll_hi = req.data;
								nxt_save = 1'b1;
							end else if (req.addr == (basic_ff ? `MMCM_STORE_BASIC
								: `MMCM_STORE_LOW)) begin
								nxt_store_lo = req.data;
							end else if (!basic_ff && req.addr == `MMCM_STORE_HIGH) begin
								nxt_store_hi = req.data;
							end
						end
						MMCM_VAL_RD: begin
							// fetch fresh value before answering
							nxt_resp_valid = 1'b0;
							nxt_cmd_valid = 1'b1;
							nxt_cmd = '{1'b0, req.addr[4:0], 16'h0000, 8'h00};
							nxt_state = MMCM_ST_MRD;
						end
						MMCM_VAL_WR: begin
							// early answer only with the delay coil on
							nxt_resp_valid = delay_on;
							nxt_resp_data = req.data;
							nxt_cmd_valid = 1'b1;
							nxt_cmd = '{1'b1, req.addr[4:0], req.data,
								store_all[req.addr[4:0]] ? `MMCM_TERM_STORE
								: `MMCM_TERM_SKIP};
							nxt_state = MMCM_ST_MWR;
						end
						default: nxt_resp_valid = 1'b0;
					endcase
				end else if (boot_ff || poll_all[idx_ff]) begin
					// sweep all at power-up, else only enabled values
					nxt_cmd_valid = 1'b1;
					nxt_cmd = '{1'b0, idx_ff, 16'h0000, 8'h00};
					nxt_state = MMCM_ST_BG;
				end else begin
					nxt_idx = (idx_ff >= last_idx) ? 5'h00 : idx_ff + 5'h01;
				end
			end
			MMCM_ST_BG: begin
				if (meter_done) begin
					nxt_cmd_valid = 1'b0;
					nxt_state = MMCM_ST_IDLE;
					nxt_idx = (idx_ff >= last_idx) ? 5'h00 : idx_ff + 5'h01;
					if (idx_ff >= last_idx) begin
						nxt_boot = 1'b0;
					end
				end
			end
			MMCM_ST_MRD, MMCM_ST_MRB: begin
				if (meter_done) begin
					nxt_cmd_valid = 1'b0;
					nxt_resp_valid = 1'b1;
					nxt_resp_data = meter_rdata;
					nxt_state = MMCM_ST_IDLE;
				end
			end
			MMCM_ST_MWR: begin
				if (meter_done) begin
					// read back before answering when the delay coil is off
					nxt_cmd_valid = !delay_on;
					nxt_cmd.write = 1'b0;
					nxt_state = delay_on ? MMCM_ST_IDLE : MMCM_ST_MRB;
				end
			end
		endcase
	end

	// state registers, factory values on reset
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state_ff <= MMCM_ST_IDLE;
			basic_ff <= 1'b0;
			caught_ff <= 1'b0;
			boot_ff <= 1'b1;
			poll_lo_ff <= `MMCM_POLL_FACTORY;
			poll_hi_ff <= `MMCM_POLL_FACTORY;
			store_lo_ff <= `MMCM_STORE_FACTORY;
			store_hi_ff <= `MMCM_STORE_FACTORY;
			idx_ff <= 5'h00;
			resp_valid_ff <= 1'b0;
			resp_data_ff <= 16'h0000;
			force_ff <= 1'b0;
			force_val_ff <= 4'h0;
			rst_ff <= 1'b0;
			rst_mask_ff <= 16'h0000;
			cmd_valid_ff <= 1'b0;
			cmd_ff <= '0;
			save_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			basic_ff <= nxt_basic;
			caught_ff <= nxt_caught;
			boot_ff <= nxt_boot;
			poll_lo_ff <= nxt_poll_lo;
			poll_hi_ff <= nxt_poll_hi;
			store_lo_ff <= nxt_store_lo;
			store_hi_ff <= nxt_store_hi;
			idx_ff <= nxt_idx;
			resp_valid_ff <= nxt_resp_valid;
			resp_data_ff <= nxt_resp_data;
			force_ff <= nxt_force;
			force_val_ff <= nxt_force_val;
			rst_ff <= nxt_rst;
			rst_mask_ff <= nxt_rst_mask;
			cmd_valid_ff <= nxt_cmd_valid;
			cmd_ff <= nxt_cmd;
			save_ff <= nxt_save;
		end
	end

	assign resp_valid = resp_valid_ff;
	assign resp_data = resp_data_ff;
	assign out_force_valid = force_ff;
	assign out_force_value = force_val_ff;
	assign reset_valid = rst_ff;
	assign reset_mask = rst_mask_ff;
	assign meter_cmd_valid = cmd_valid_ff;
	assign meter_cmd = cmd_ff;
	assign nv_save_valid = save_ff;
	assign nv_save_data = poll_all;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	property p_out_read;
		take && req.kind == MMCM_COIL_RD && req.addr == 16'h0000
			|=> resp_valid && resp_data[0] == $past(setpoint_state[0]);
	endproperty
	a_out_read: assert property (p_out_read) else $error("output coil read wrong");
	property p_out_manual;
		take && req.kind == MMCM_COIL_WR && cm.sel == MMCM_SEL_OUT
			|=> out_force_valid == $past(manual_mode[req.addr[1:0]]);
	endproperty
	a_out_manual: assert property (p_out_manual) else $error("force ignored mode");
	property p_reset_pulse;
		take && req.kind == MMCM_COIL_WR && cm.sel == MMCM_SEL_RST && req.data[0]
			|=> reset_valid && reset_mask == (16'h0001 << $past(cm.bitn));
	endproperty
	a_reset_pulse: assert property (p_reset_pulse) else $error("no reset pulse");
	property p_rst_zero;
		take && req.kind == MMCM_COIL_RD && cm.sel == MMCM_SEL_RST |=> resp_data == 16'h0000;
	endproperty
	a_rst_zero: assert property (p_rst_zero) else $error("reset coil not zero");
	property p_bg_mask;
		state_ff == MMCM_ST_BG && !boot_ff |-> poll_all[meter_cmd.idx];
	endproperty
	a_bg_mask: assert property (p_bg_mask) else $error("disabled value polled");
	property p_fresh_read;
		take && req.kind == MMCM_VAL_RD
			|=> meter_cmd_valid && !meter_cmd.write && meter_cmd.idx == $past(req.addr[4:0])
			&& !resp_valid;
	endproperty
	a_fresh_read: assert property (p_fresh_read) else $error("read not refreshed");
	property p_term;
		meter_cmd_valid && meter_cmd.write |-> meter_cmd.term == (store_all[meter_cmd.idx]
			? `MMCM_TERM_STORE : `MMCM_TERM_SKIP);
	endproperty
	a_term: assert property (p_term) else $error("wrong terminator");
	property p_delay;
		take && req.kind == MMCM_VAL_WR |=> resp_valid == $past(delay_on);
	endproperty
	a_delay: assert property (p_delay) else $error("response delay wrong");
	property p_nv_save;
		take && req.kind == MMCM_COIL_WR && cm.sel inside {MMCM_SEL_PLO, MMCM_SEL_PHI}
			|=> nv_save_valid;
	endproperty
	a_nv_save: assert property (p_nv_save) else $error("poll not saved");
	c_boot_done: cover property (boot_ff ##1 !boot_ff);
	c_val_wr_rb: cover property (state_ff == MMCM_ST_MWR ##1 state_ff == MMCM_ST_MRB);
	c_force: cover property (out_force_valid);
endmodule

// [tb/mmcm_meter_model.sv]
// meter side of the card link: answers each command after a set latency
// assumes commands are held until done, as the coil map drives them
`timescale 1ns/1ps
module mmcm_meter_model import mmcm_pkg::*; (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic meter_cmd_valid,
	input wire mmcm_meter_cmd_t meter_cmd,
	input wire logic [7:0] lat,
	input wire logic clr,
	output logic meter_done,
	output logic [15:0] meter_rdata,
	output logic [31:0] seen,
	output logic [7:0] last_term,
	output int n_wr
);
	logic [7:0] cnt; // cycles spent on the current command
	// answer after lat cycles; out of reset, data line toggles whenever no answer is shown
	always @(posedge ref_clk) begin
		meter_done <= 1'b0;
		meter_rdata <= ~meter_rdata;
		if (!reset_n) begin
			cnt <= 8'h00;
			seen <= 32'h0;
			n_wr <= 0;
			last_term <= 8'h00;
			meter_rdata <= 16'h0f0f;
		end else if (meter_cmd_valid && !meter_done) begin
			if (cnt >= lat) begin
				// value read is a fixed tag plus the index
				meter_done <= 1'b1;
				meter_rdata <= 16'h5a00 | {11'h0, meter_cmd.idx};
				cnt <= 8'h00;
				if (meter_cmd.write) begin
					n_wr <= n_wr + 1;
					last_term <= meter_cmd.term;
				end else begin
					seen[meter_cmd.idx] <= 1'b1;
				end
			end else begin
				cnt <= cnt + 8'h01;
			end
		end
		if (clr) begin
			seen <= 32'h0;
		end
	end
endmodule

// [tb/mmcm_coil_map_tb_top.sv]
// self-checking bench of the coil map against a meter model
// assumes the map header and package are on the include path
`timescale 1ns/1ps
`include "mmcm_map.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
	$display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module mmcm_coil_map_tb_top import mmcm_pkg::*;;
	logic ref_clk = 1'b0; // 20 MHz clock
	logic reset_n, meter_is_basic, req_valid, req_ready, resp_valid;
	mmcm_req_t req; // request to the map
	logic [15:0] resp_data, reset_mask, meter_rdata, nv_poll_low, nv_poll_high;
	logic [3:0] setpoint_state, manual_mode, out_force_value;
	logic out_force_valid, reset_valid, meter_cmd_valid, meter_done, nv_valid, nv_save_valid;
	mmcm_meter_cmd_t meter_cmd; // command to the meter
	logic [31:0] nv_save_data, seen;
	logic [7:0] lat, last_term;
	logic clr;
	int n_wr, miscompares, n_tests, n_force, n_rst, n_save, cyc, k, i;
	logic [15:0] rd, last_mask; // last answer and last reset word
	logic [3:0] last_force; // last forced output word
	mmcm_coil_map i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .meter_is_basic(meter_is_basic),
		.req_valid(req_valid), .req(req), .req_ready(req_ready), .resp_valid(resp_valid),
		.resp_data(resp_data), .setpoint_state(setpoint_state), .manual_mode(manual_mode),
		.out_force_valid(out_force_valid), .out_force_value(out_force_value),
		.reset_valid(reset_valid), .reset_mask(reset_mask), .meter_cmd_valid(meter_cmd_valid),
		.meter_cmd(meter_cmd), .meter_done(meter_done), .meter_rdata(meter_rdata),
		.nv_valid(nv_valid), .nv_poll_low(nv_poll_low), .nv_poll_high(nv_poll_high),
		.nv_save_valid(nv_save_valid), .nv_save_data(nv_save_data));
	mmcm_meter_model i_meter (.ref_clk(ref_clk), .reset_n(reset_n),
		.meter_cmd_valid(meter_cmd_valid), .meter_cmd(meter_cmd), .lat(lat), .clr(clr),
		.meter_done(meter_done), .meter_rdata(meter_rdata), .seen(seen),
		.last_term(last_term), .n_wr(n_wr));
	// clock
	always #25 ref_clk = ~ref_clk;
	// pulse monitor, sampled mid-cycle where outputs are settled
	always @(negedge ref_clk) begin
		if (out_force_valid === 1'b1) begin
			n_force++;
			last_force = out_force_value;
		end
		if (reset_valid === 1'b1) begin
			n_rst++;
			last_mask = reset_mask;
		end
		if (nv_save_valid === 1'b1) begin
			n_save++;
		end
	end
	// one request: hold until taken, then wait for the answer pulse
	task automatic xfer(input mmcm_kind_t kd, input logic [15:0] a, input logic [15:0] d);
		int w;
		w = 0;
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req <= '{kind: kd, addr: a, data: d};
		@(negedge ref_clk);
		while (req_ready !== 1'b1 && w < 4000) begin
			@(negedge ref_clk);
			w++;
		end
		@(posedge ref_clk);
		req_valid <= 1'b0;
		// answer pulse stands one cycle: look at the negedge right after the take
		cyc = 1;
		@(negedge ref_clk);
		while (resp_valid !== 1'b1 && cyc < 4000) begin
			@(negedge ref_clk);
			cyc++;
		end
		// a handshake limit that runs out counts as a mismatch
		if (resp_valid !== 1'b1 || w >= 4000) begin
			miscompares++;
		end
		rd = resp_data;
		#1;
	endtask
	// reset held 20 cycles, strap and restore pulse chosen
	task automatic do_reset(input logic basic, input logic nv);
		@(posedge ref_clk);
		reset_n <= 1'b0;
		meter_is_basic <= basic;
		nv_valid <= nv;
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
	endtask
	// clear the fetch record, then let the loop run
	task automatic run_loop;
		@(posedge ref_clk);
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
		repeat (100) @(posedge ref_clk);
	endtask
	// basic meter: factory words, delay bit, total reset coil
	task automatic t_factory;
		do_reset(1'b1, 1'b0);
		xfer(MMCM_REG_RD, `MMCM_POLL_BASIC, 16'h0);
		`CHK(rd, `MMCM_POLL_FACTORY)
		xfer(MMCM_COIL_RD, 16'h000a, 16'h0);
		`CHK(rd[0], 1'b1)
		xfer(MMCM_REG_RD, `MMCM_STORE_BASIC, 16'h0);
		`CHK(rd, `MMCM_STORE_FACTORY)
		xfer(MMCM_REG_RD, 16'h9c40, 16'h0);
		`CHK(rd, `MMCM_UNUSED_READ)
		xfer(MMCM_COIL_WR, 16'h001d, 16'h0);
		xfer(MMCM_REG_RD, `MMCM_POLL_BASIC, 16'h0);
		`CHK(rd, 16'hfbff)
		xfer(MMCM_COIL_WR, 16'h0009, 16'h1);
		`CHK(last_mask, 16'h0010)
		xfer(MMCM_COIL_RD, 16'h0009, 16'h0);
		`CHK(rd[0], 1'b0)
	endtask
	// extended meter restored with all polls off: boot sweep only
	task automatic t_boot;
		int w;
		w = 0;
		do_reset(1'b0, 1'b1);
		while (seen[18:0] !== 19'h7ffff && w < 3000) begin
			@(posedge ref_clk);
			w++;
		end
		`CHK(seen[18:0], 19'h7ffff)
		nv_valid <= 1'b0;
		xfer(MMCM_REG_RD, `MMCM_POLL_LOW, 16'h0);
		`CHK(rd, 16'h0000)
		xfer(MMCM_REG_RD, `MMCM_POLL_HIGH, 16'h0);
		`CHK(rd, 16'h0000)
		run_loop;
		`CHK(seen, 32'h0)
	endtask
	// one poll coil on: mirrored, saved and looped alone
	task automatic t_poll;
		k = n_save;
		xfer(MMCM_COIL_WR, 16'h000f, 16'h1);
		xfer(MMCM_REG_RD, `MMCM_POLL_LOW, 16'h0);
		`CHK(rd, 16'h0020)
		`CHK(n_save, k + 1)
		`CHK(nv_save_data, 32'h0000_0020)
		run_loop;
		`CHK(seen, 32'h0000_0020)
		xfer(MMCM_REG_WR, `MMCM_POLL_LOW, 16'h0);
		xfer(MMCM_COIL_RD, 16'h000f, 16'h0);
		`CHK(rd[0], 1'b0)
	endtask
	// output coils read state, force only in manual mode
	task automatic t_outputs;
		@(posedge ref_clk);
		setpoint_state <= 4'h5;
		manual_mode <= 4'h0;
		for (i = 0; i < 4; i++) begin
			xfer(MMCM_COIL_RD, i[15:0], 16'h0);
			`CHK(rd[0], (i == 0 || i == 2))
		end
		k = n_force;
		xfer(MMCM_COIL_WR, 16'h0001, 16'h1);
		`CHK(n_force, k)
		@(posedge ref_clk);
		manual_mode <= 4'h2;
		xfer(MMCM_COIL_WR, 16'h0001, 16'h1);
		`CHK(n_force, k + 1)
		`CHK(last_force, 4'h7)
	endtask
	// every extended reset coil pulses its word bit and reads zero
	task automatic t_resets;
		logic [3:0] rb [5];
		rb = '{4'h2, 4'h3, 4'h7, 4'h6, 4'h5};
		for (i = 0; i < 5; i++) begin
			xfer(MMCM_COIL_WR, 16'h0004 + i[15:0], 16'h1);
			`CHK(last_mask, 16'h0001 << rb[i])
			xfer(MMCM_COIL_RD, 16'h0004 + i[15:0], 16'h0);
			`CHK(rd[0], 1'b0)
		end
		xfer(MMCM_REG_RD, `MMCM_RESET_CMD, 16'h0);
		`CHK(rd, 16'h0000)
	endtask
	// value reads and writes: refresh, answer timing, terminators
	task automatic t_values;
		int w;
		w = 0;
		@(posedge ref_clk);
		lat <= 8'h05;
		xfer(MMCM_VAL_RD, 16'h0003, 16'h0);
		`CHK(rd, 16'h5a03)
		k = n_wr;
		xfer(MMCM_VAL_WR, 16'h0000, 16'h1234);
		`CHK(cyc > 10, 1'b1)
		`CHK(last_term, `MMCM_TERM_SKIP)
		xfer(MMCM_REG_WR, `MMCM_STORE_LOW, 16'h0001);
		xfer(MMCM_COIL_WR, 16'h001d, 16'h1);
		xfer(MMCM_REG_RD, `MMCM_POLL_HIGH, 16'h0);
		`CHK(rd, 16'h0008)
		xfer(MMCM_VAL_WR, 16'h0000, 16'h1234);
		`CHK(cyc, 1)
		while (n_wr < k + 2 && w < 200) begin
			@(posedge ref_clk);
			w++;
		end
		`CHK(last_term, `MMCM_TERM_STORE)
	endtask
	// verdict
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		reset_n = 1'b0;
		meter_is_basic = 1'b0;
		req_valid = 1'b0;
		req = '0;
		setpoint_state = 4'h0;
		manual_mode = 4'h0;
		nv_valid = 1'b0;
		nv_poll_low = 16'h0000;
		nv_poll_high = 16'h0000;
		lat = 8'h02;
		clr = 1'b0;
		t_factory;
		t_boot;
		t_poll;
		t_outputs;
		t_resets;
		t_values;
		tally_and_finish;
	end
	// watchdog against a hung handshake
	initial begin
		repeat (60000) @(posedge ref_clk);
		miscompares++;
		tally_and_finish;
	end
endmodule
